// file: bsec_core.sv
// bsec_core: boot selection, password lock, loader gating, stop mode and system registers.
// assumes flash, rom and tap logic run on clock_i; reset and interrupt pins are asynchronous.
`timescale 1ns/1ps

// Operation
// - every reset starts fetch in utility rom; rom then picks 0000h or a routine
// - unlock password is the sixteen program words at 0010h to 001Fh
// - lock bit one, its power-on value, blocks rom, debug and programming except erase until matched
// - lock bit zero grants rom debug and programming services with no password
// - mass erase sets every password word to all ones
// - tap is live after any reset; host loads the programming instruction
// - enable bit set over tap during reset runs the loader on reset exit
// - loader may clear enable bit then reset so the application starts
// - loader offers load, dump, crc, verify and erase
// - utility rom routines are callable from application code as subroutines
// - flash may be erased and rewritten while the application runs
// - stop mode halts crystal, rc oscillator, system clock and processing
// - stop exits only on enabled external interrupt or external reset pin
// - on exit an option waits for crystal warmup or runs on rc meanwhile
// - system registers chosen by module specifier and index, modules 8h to Fh except Ah
// - fully read-only registers ignore writes to every bit
// - wide registers hold 16 bits, the rest hold a byte
// - register field low four bits are module, upper bits the index
module bsec_core #(
	parameter int WARM_CYC = 1024,
	parameter int EXT_INTS = 8
) (
	input  wire logic                  clock_i,
	input  wire logic                  rst_i,
	input  wire logic                  ext_reset_n_i,
	input  wire logic [EXT_INTS-1:0]   ext_int_i,
	input  wire logic [EXT_INTS-1:0]   ext_int_en_i,
	input  wire logic                  tap_spe_wr_i,
	input  wire logic                  tap_spe_val_i,
	input  wire logic                  pw_try_i,
	input  wire logic [15:0]           pw_try_word_i,
	input  wire logic                  flash_wr_i,
	input  wire logic [15:0]           flash_addr_i,
	input  wire logic [15:0]           flash_data_i,
	input  wire logic                  mass_erase_i,
	input  wire logic                  loader_req_i,
	input  wire bsec_pkg::bsec_op_t    loader_op_i,
	input  wire logic [7:0]            irq_source_i,
	input  wire bsec_pkg::bsec_sreq_t  sreq_i,
	output logic [15:0]                sr_rdata_o,
	output logic                       sr_hit_o,
	output logic                       in_reset_o,
	output logic                       fetch_start_o,
	output logic [15:0]                fetch_addr_o,
	output logic                       loader_mode_o,
	output logic [15:0]                app_entry_o,
	output logic                       debug_grant_o,
	output logic                       loader_op_ok_o,
	output logic                       rom_call_ok_o,
	output logic                       iap_ok_o,
	output bsec_pkg::bsec_clk_t        clk_ctl_o
);
	import bsec_pkg::*;

	typedef struct packed {
		bsec_mode_t             mode;
		logic [15:0]            warm;
		logic                   rst_s1;
		logic                   rst_s2;
		logic                   rst_old;
		logic [EXT_INTS-1:0]    int_s1;
		logic [EXT_INTS-1:0]    int_s2;
		logic                   system_programming_enable;
		logic [PW_WORDS-1:0][15:0] pw;
		logic [4:0]             pw_pos;
		logic                   unlocked;
		logic                   start;
		logic [7:0]             ap;
		logic [7:0]             accumulator_pointer_control;
		logic [7:0]             processor_flags;
		logic [7:0]             ic;
		logic [7:0]             module_interrupt_mask;
		logic [7:0]             sc;
		logic [7:0]             clock_control;
		logic [7:0]             watchdog_control;
		logic [15:0][15:0]      acc;
		logic [PFX_CNT-1:0][15:0] prefix_register;
		logic [15:0]            ip;
		logic [15:0]            sp;
		logic [15:0]            iv;
		logic [15:0]            lc0;
		logic [15:0]            lc1;
		logic [7:0]             frame_index_displacement;
		logic [15:0]            pointer_control;
		logic [15:0]            gr;
		logic [15:0]            bp;
		logic [15:0]            dp0;
		logic [15:0]            dp1;
		logic [15:0]            rdata;
		logic                   hit;
	} bsec_st_t;

	localparam logic [15:0] WARM_LAST = 16'(WARM_CYC - 1);
	localparam logic [4:0]  PW_FULL   = 5'(PW_WORDS);

	bsec_st_t q;
	bsec_st_t d;
	logic     ext_rst;
	logic     granted;
	logic     wake;
	logic [3:0] mod;
	logic [3:0] idx;
	logic [15:0] wd;

	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [15:0] nw,
		input logic [7:0] mask);
		merge8 = (old & ~mask) | (nw[7:0] & mask);
	endfunction : merge8

	function automatic logic [15:0] zx8(input logic [7:0] v);
		zx8 = {8'h00, v};
	endfunction : zx8

	assign ext_rst = ~q.rst_s2;
	assign granted = ~q.sc[SC_PWL_BIT] | q.unlocked;
	assign wake    = ext_rst | (|(q.int_s2 & ext_int_en_i));
	assign mod     = sreq_i.addr[3:0];
	assign idx     = sreq_i.addr[7:4];
	assign wd      = sreq_i.wdata;

	always_comb begin
		d = q;
		d.rst_s1  = ext_reset_n_i;
		d.rst_s2  = q.rst_s1;
		d.rst_old = ext_rst;
		d.int_s1  = ext_int_i;
		d.int_s2  = q.int_s1;
		d.hit     = 1'b0;
		d.rdata   = WORD_RST;
		// a reset release restarts fetch in rom whatever the previous state
		d.start   = q.rst_old & ~ext_rst;

		// shadow of the password words kept in step with flash
		if (mass_erase_i) begin
			for (int i = 0; i < PW_WORDS; i++) begin
				d.pw[i] = WORD_ONES;
			end
		end else if (flash_wr_i && flash_addr_i >= PW_FIRST && flash_addr_i <= PW_LAST) begin
			d.pw[flash_addr_i[3:0]] = flash_data_i;
		end

		// words compared one by one; a miss restarts the sequence
		if (pw_try_i && !q.unlocked) begin
			if (pw_try_word_i == q.pw[q.pw_pos[3:0]]) begin
				d.pw_pos = q.pw_pos + 5'd1;
				d.unlocked = (q.pw_pos + 5'd1) == PW_FULL;
			end else begin
				d.pw_pos = 5'd0;
			end
		end

		if (ext_rst) begin
			// tap stays usable in reset, only here can it set the enable bit
			if (tap_spe_wr_i) begin
				d.system_programming_enable = tap_spe_val_i;
			end
			d.mode     = BSEC_RUN;
			d.warm     = WORD_RST;
			d.unlocked = 1'b0;
			d.pw_pos   = 5'd0;
			d.ap   = BYTE_RST;
			d.accumulator_pointer_control  = BYTE_RST;
			d.processor_flags  = PSF_RST;
			d.ic   = BYTE_RST;
			d.module_interrupt_mask  = BYTE_RST;
			// lock bit survives a non power-on reset
			d.sc   = SC_RST | (q.sc & (8'h01 << SC_PWL_BIT));
			d.clock_control = BYTE_RST;
			d.watchdog_control = BYTE_RST;
			d.ip   = ROM_BASE;
			d.sp   = SP_RST;
			d.iv   = WORD_RST;
			d.frame_index_displacement = BYTE_RST;
			d.pointer_control  = WORD_RST;
		end else begin
			case (q.mode)
				BSEC_RUN: begin
					if (q.clock_control[CK_STOP_BIT]) begin
						d.mode = BSEC_STOP;
					end
				end
				BSEC_STOP: begin
					if (wake) begin
						d.clock_control[CK_STOP_BIT] = 1'b0;
						d.warm = WORD_RST;
						d.mode = BSEC_WARM;
					end
				end
				BSEC_WARM: begin
					d.warm = q.warm + 16'd1;
					if (q.warm == WARM_LAST) begin
						d.mode = BSEC_RUN;
					end
				end
				default: d.mode = BSEC_RUN;
			endcase

			if (sreq_i.rd && q.mode != BSEC_STOP) begin
				d.hit = 1'b1;
				if (mod == MOD_AP) begin
					if      (idx == IX_AP)   d.rdata = zx8(q.ap);
					else if (idx == IX_APC)  d.rdata = zx8(q.accumulator_pointer_control);
					else if (idx == IX_PSF)  d.rdata = zx8(q.processor_flags);
					else if (idx == IX_IC)   d.rdata = zx8(q.ic);
					else if (idx == IX_IMR)  d.rdata = zx8(q.module_interrupt_mask);
					else if (idx == IX_SC)   d.rdata = zx8(q.sc | (8'(q.system_programming_enable) << SC_SPE_BIT));
					else if (idx == IX_IIR)  d.rdata = zx8(irq_source_i);
					else if (idx == IX_CLOCK_CONTROL) d.rdata = zx8(q.clock_control);
					else if (idx == IX_WATCHDOG_CONTROL) d.rdata = zx8(q.watchdog_control);
					else d.hit = 1'b0;
				end else if (mod == MOD_A) begin
					d.rdata = q.acc[idx];
				end else if (mod == MOD_PFX && idx < 4'(PFX_CNT)) begin
					d.rdata = q.prefix_register[idx[2:0]];
				end else if (mod == MOD_IP && idx == IX_IP) begin
					d.rdata = q.ip;
				end else if (mod == MOD_SP) begin
					if      (idx == IX_SP)  d.rdata = q.sp;
					else if (idx == IX_IV)  d.rdata = q.iv;
					else if (idx == IX_LC0) d.rdata = q.lc0;
					else if (idx == IX_LC1) d.rdata = q.lc1;
					else d.hit = 1'b0;
				end else if (mod == MOD_DPC) begin
					if      (idx == IX_FRAME_INDEX_DISPLACEMENT) d.rdata = zx8(q.frame_index_displacement);
					else if (idx == IX_DPC)  d.rdata = q.pointer_control;
					else if (idx == IX_GR)   d.rdata = q.gr;
					else if (idx == IX_GRL)  d.rdata = zx8(q.gr[7:0]);
					else if (idx == IX_BP)   d.rdata = q.bp;
					else if (idx == IX_GRS)  d.rdata = {q.gr[7:0], q.gr[15:8]};
					else if (idx == IX_GRH)  d.rdata = zx8(q.gr[15:8]);
					else if (idx == IX_GENERAL_REGISTER_SIGN_EXTENDED_LOW) d.rdata = {{8{q.gr[7]}}, q.gr[7:0]};
					else if (idx == IX_FP)   d.rdata = q.bp + zx8(q.frame_index_displacement);
					else d.hit = 1'b0;
				end else if (mod == MOD_DP) begin
					if      (idx == IX_DP0) d.rdata = q.dp0;
					else if (idx == IX_DP1) d.rdata = q.dp1;
					else d.hit = 1'b0;
				end else begin
					d.hit = 1'b0;
				end
			end

			// read-only registers (source id, swapped, sign extended, frame) have no write arm
			if (sreq_i.wr && q.mode != BSEC_STOP) begin
				if (mod == MOD_AP) begin
					if      (idx == IX_AP)   d.ap   = merge8(q.ap, wd, AP_WMASK);
					else if (idx == IX_APC)  d.accumulator_pointer_control  = merge8(q.accumulator_pointer_control, wd, APC_WMASK);
					else if (idx == IX_PSF)  d.processor_flags  = merge8(q.processor_flags, wd, PSF_WMASK);
					else if (idx == IX_IC)   d.ic   = merge8(q.ic, wd, IC_WMASK);
					else if (idx == IX_IMR)  d.module_interrupt_mask  = merge8(q.module_interrupt_mask, wd, IMR_WMASK);
					else if (idx == IX_SC) begin
						d.sc = merge8(q.sc, wd, SC_WMASK);
						// software may only drop the lock, and only once granted
						if (!wd[SC_PWL_BIT] && granted) begin
							d.sc[SC_PWL_BIT] = 1'b0;
						end
						if (!wd[SC_SPE_BIT] && q.system_programming_enable) begin
							d.system_programming_enable = 1'b0;
						end
					end
					else if (idx == IX_CLOCK_CONTROL) d.clock_control = merge8(q.clock_control, wd, CLOCK_CONTROL_WMASK);
					else if (idx == IX_WATCHDOG_CONTROL) d.watchdog_control = merge8(q.watchdog_control, wd, WATCHDOG_CONTROL_WMASK);
				end else if (mod == MOD_A) begin
					d.acc[idx] = wd;
				end else if (mod == MOD_PFX && idx < 4'(PFX_CNT)) begin
					d.prefix_register[idx[2:0]] = wd;
				end else if (mod == MOD_IP && idx == IX_IP) begin
					d.ip = wd;
				end else if (mod == MOD_SP) begin
					if      (idx == IX_SP)  d.sp  = wd;
					else if (idx == IX_IV)  d.iv  = wd;
					else if (idx == IX_LC0) d.lc0 = wd;
					else if (idx == IX_LC1) d.lc1 = wd;
				end else if (mod == MOD_DPC) begin
					if      (idx == IX_FRAME_INDEX_DISPLACEMENT) d.frame_index_displacement = wd[7:0];
					else if (idx == IX_DPC)  d.pointer_control = wd;
					else if (idx == IX_GR)   d.gr = wd;
					else if (idx == IX_GRL)  d.gr[7:0] = wd[7:0];
					else if (idx == IX_BP)   d.bp = wd;
					else if (idx == IX_GRH)  d.gr[15:8] = wd[7:0];
				end else if (mod == MOD_DP) begin
					if      (idx == IX_DP0) d.dp0 = wd;
					else if (idx == IX_DP1) d.dp1 = wd;
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			q <= '0;
			q.mode <= BSEC_RUN;
			q.pw   <= {PW_WORDS{WORD_ONES}};
			q.sc   <= SC_RST | (8'h01 << SC_PWL_BIT);
			q.processor_flags  <= PSF_RST;
			q.sp   <= SP_RST;
			q.ip   <= ROM_BASE;
			q.rst_old <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs
	assign sr_rdata_o     = q.rdata;
	assign sr_hit_o       = q.hit;
	assign in_reset_o     = ext_rst;
	assign fetch_start_o  = q.start;
	assign fetch_addr_o   = ROM_BASE;
	assign loader_mode_o  = q.system_programming_enable;
	assign app_entry_o    = APP_ENTRY;
	assign debug_grant_o  = granted;
	// erase stays open when locked: it wipes the code it would protect
	assign loader_op_ok_o = loader_req_i & q.system_programming_enable & ~ext_rst &
		((loader_op_i == BSEC_OP_ERASE) |
		 (granted & (loader_op_i == BSEC_OP_LOAD || loader_op_i == BSEC_OP_DUMP ||
		  loader_op_i == BSEC_OP_CRC || loader_op_i == BSEC_OP_VERIFY)));
	// application calls into rom need no password
	assign rom_call_ok_o  = ~ext_rst & (q.mode != BSEC_STOP);
	assign iap_ok_o       = ~ext_rst & (q.mode != BSEC_STOP);
	assign clk_ctl_o.osc_en  = q.mode != BSEC_STOP;
	assign clk_ctl_o.rc_en   = q.mode != BSEC_STOP;
	assign clk_ctl_o.clk_run = q.mode == BSEC_RUN ||
		(q.mode == BSEC_WARM && !q.clock_control[CK_WAITXT_BIT]);
	assign clk_ctl_o.on_rc   = q.mode == BSEC_WARM;

endmodule : bsec_core

// file: bsec_core_monitor.sv
// bsec_core_monitor: port assertions for the boot, security and register block.
// assumes bind onto bsec_core, rst_i synchronous, and a bench warm-up count of 8.
`timescale 1ns/1ps
module bsec_core_monitor #(
	parameter int WARM_CYC = 1024,
	parameter int EXT_INTS = 8
) (
	input wire logic                 clock_i,
	input wire logic                 rst_i,
	input wire logic                 ext_reset_n_i,
	input wire logic [EXT_INTS-1:0]  ext_int_i,
	input wire logic [EXT_INTS-1:0]  ext_int_en_i,
	input wire logic                 tap_spe_wr_i,
	input wire logic                 tap_spe_val_i,
	input wire logic                 pw_try_i,
	input wire logic                 loader_req_i,
	input wire bsec_pkg::bsec_op_t   loader_op_i,
	input wire bsec_pkg::bsec_sreq_t sreq_i,
	input wire logic [15:0]          sr_rdata_o,
	input wire logic                 sr_hit_o,
	input wire logic                 in_reset_o,
	input wire logic                 fetch_start_o,
	input wire logic                 loader_mode_o,
	input wire logic                 debug_grant_o,
	input wire logic                 loader_op_ok_o,
	input wire bsec_pkg::bsec_clk_t  clk_ctl_o
);
	import bsec_pkg::*;
	default clocking mon_cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	logic quiet;
	// raw pins: three quiet cycles outlast the two-flop synchroniser
	assign quiet = ~|(ext_int_i & ext_int_en_i) & ext_reset_n_i;
	sequence stop_req_s;
		sreq_i.wr && sreq_i.addr == {IX_CLOCK_CONTROL, MOD_AP} && sreq_i.wdata[CK_STOP_BIT] &&
			!in_reset_o && clk_ctl_o.clk_run && !clk_ctl_o.on_rc;
	endsequence
	sequence halted_quiet_s;
		(clk_ctl_o == 4'h0 && quiet) [*3];
	endsequence
	// count tied to the bench warm-up of 8
	sequence warm_s;
		clk_ctl_o.on_rc [*8] ##1 !clk_ctl_o.on_rc;
	endsequence
	chk_fetch_after: assert property ($fell(in_reset_o) |-> ##[0:2] fetch_start_o)
		else $error("no fetch start after reset release");
	chk_unmapped_zero: assert property (sreq_i.rd &&
		(sreq_i.addr[3:0] < MOD_AP || sreq_i.addr[3:0] == 4'hA) |=>
		!sr_hit_o && sr_rdata_o == 16'h0000) else $error("unmapped read not zero");
	chk_spe_taken: assert property (tap_spe_wr_i && in_reset_o |=>
		loader_mode_o == $past(tap_spe_val_i)) else $error("tap enable write lost");
	chk_spe_refused: assert property (tap_spe_wr_i && !in_reset_o && !sreq_i.wr |=>
		$stable(loader_mode_o)) else $error("tap enable written outside reset");
	// write lands on the first edge, the mode register follows on the next
	chk_stop_halts: assert property (stop_req_s |-> ##2 clk_ctl_o == 4'h0)
		else $error("stop request left a clock running");
	chk_stop_holds: assert property (halted_quiet_s |=> clk_ctl_o == 4'h0)
		else $error("stop left without a wake source");
	chk_warm_span: assert property (disable iff (rst_i || in_reset_o)
		$rose(clk_ctl_o.on_rc) |-> warm_s) else $error("warm-up span wrong");
	chk_grant_cause: assert property ($rose(debug_grant_o) |-> $past(pw_try_i))
		else $error("debug granted without a password word");
	chk_loader_gate: assert property (loader_op_ok_o |-> loader_req_i &&
		(loader_op_i == BSEC_OP_ERASE || (debug_grant_o && loader_mode_o)))
		else $error("loader operation granted while locked");
endmodule : bsec_core_monitor

bind bsec_core bsec_core_monitor #(.WARM_CYC(WARM_CYC), .EXT_INTS(EXT_INTS)) u_mon (.*);

// file: bsec_core_test.sv
// bsec_core_test: self-checking random bench for the boot, security and register block.
// assumes bsec_core, bsec_jtag_host and the bound monitor are compiled alongside.
`timescale 1ns/1ps
module bsec_core_test;
	import bsec_pkg::*;
	logic        clock_i = 1'b0, rst_i = 1'b1, ext_reset_n_i = 1'b1, pw_try_i = 1'b0;
	logic [7:0]  ext_int_i = 8'h00, ext_int_en_i = 8'h00, irq_source_i = 8'h00;
	logic        tap_spe_wr_i, tap_spe_val_i, flash_wr_i = 1'b0, mass_erase_i = 1'b0;
	logic [15:0] pw_try_word_i = 16'h0000, flash_addr_i = 16'h0000, flash_data_i = 16'h0000;
	logic        loader_req_i = 1'b0, host_req = 1'b0, host_any = 1'b0, host_val = 1'b0;
	bsec_op_t    loader_op_i = BSEC_OP_LOAD;
	bsec_sreq_t  sreq_i = '0;
	logic [15:0] sr_rdata_o, fetch_addr_o, app_entry_o, d, pw_q [16], acc_q [16];
	logic        sr_hit_o, in_reset_o, fetch_start_o, loader_mode_o, debug_grant_o, h;
	logic        loader_op_ok_o, rom_call_ok_o, iap_ok_o;
	bsec_clk_t   clk_ctl_o;
	logic [1:0]  host_lag = 2'h0;
	logic [7:0]  rst_a [5] = '{8'h08, 8'h48, 8'h88, 8'h1D, 8'h2D};
	logic [15:0] rst_v [5] = '{16'h0000, 16'h0080, 16'h0082, 16'h000F, 16'h0000};
	logic [7:0]  by_a [3] = '{8'h08, 8'h58, 8'h68};
	logic [7:0]  by_m [3] = '{AP_WMASK, IC_WMASK, IMR_WMASK};
	int          mismatches = 0, cmp_count = 0, seed = 92;

	always #2 clock_i = ~clock_i;
	bsec_core #(.WARM_CYC(8)) dut (.*);
	bsec_jtag_host host (.clock_i(clock_i), .in_reset_i(in_reset_o), .req_i(host_req),
		.any_i(host_any), .val_i(host_val), .lag_i(host_lag),
		.tap_spe_wr_o(tap_spe_wr_i), .tap_spe_val_o(tap_spe_val_i));

	function automatic logic exp_ok(input bsec_op_t op, input logic g, input logic s);
		return op == BSEC_OP_ERASE || (g && s);
	endfunction : exp_ok
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic results;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc
	task automatic sr_wr(input logic [7:0] a, input logic [15:0] v);
		@(negedge clock_i);
		sreq_i = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(negedge clock_i);
		sreq_i.wr = 1'b0;
	endtask : sr_wr
	task automatic sr_rd(input logic [7:0] a);
		@(negedge clock_i);
		sreq_i.rd = 1'b1;
		sreq_i.addr = a;
		@(negedge clock_i);
		sreq_i.rd = 1'b0;
		d = sr_rdata_o;
		h = sr_hit_o;
	endtask : sr_rd
	task automatic fl_wr(input logic [15:0] a, input logic [15:0] v);
		@(negedge clock_i);
		flash_wr_i = 1'b1;
		flash_addr_i = a;
		flash_data_i = v;
		@(negedge clock_i);
		flash_wr_i = 1'b0;
	endtask : fl_wr
	task automatic pw_send(input int bad, input logic grant);
		for (int k = 0; k < PW_WORDS; k++) begin
			@(negedge clock_i);
			pw_try_i = 1'b1;
			pw_try_word_i = (k == bad) ? ~pw_q[k] : pw_q[k];
		end
		cyc(1);
		pw_try_i = 1'b0;
		cyc(1);
		check("debug_grant", debug_grant_o, grant);
	endtask : pw_send
	task automatic ops(input logic g, input logic s);
		loader_req_i = 1'b1;
		for (int k = 0; k < 5; k++) begin
			loader_op_i = bsec_op_t'(k);
			cyc(1);
			check("loader_ok", loader_op_ok_o, exp_ok(loader_op_i, g, s));
		end
		loader_req_i = 1'b0;
	endtask : ops
	task automatic ext_rst(input logic wr, input logic val);
		host_val = val;
		host_lag = 2'($random(seed));
		host_req = wr;
		ext_reset_n_i = 1'b0;
		cyc(8);
		check("in_reset", in_reset_o, 1'b1);
		check("rom_call_ok", rom_call_ok_o, 1'b0);
		host_req = 1'b0;
		ext_reset_n_i = 1'b1;
		for (int i = 0; i < 8 && fetch_start_o !== 1'b1; i++)
			@(negedge clock_i);
		check("fetch_start", fetch_start_o, 1'b1);
	endtask : ext_rst

	initial begin
		#200000;
		mismatches++;
		$display("unexpected watchdog: run did not finish");
		results();
	end
	initial begin
		cyc(3);
		rst_i = 1'b0;
		cyc(3);
		check("fetch_addr", fetch_addr_o, ROM_BASE);
		check("app_entry", app_entry_o, APP_ENTRY);
		check("calls_ok", {rom_call_ok_o, iap_ok_o}, 2'h3);
		for (int k = 0; k < 5; k++) begin
			sr_rd(rst_a[k]);
			check("reset_value", d, rst_v[k]);
		end
		for (int k = 0; k < 16; k++) begin
			acc_q[k] = 16'($random(seed));
			sr_wr({4'(k), MOD_A}, acc_q[k]);
		end
		sr_wr(8'h38, 16'h5A5A);
		sr_wr(8'h2A, 16'hA5A5);
		for (int k = 0; k < 16; k++) begin
			sr_rd({4'(k), MOD_A});
			check("acc", {h, d}, {1'b1, acc_q[k]});
		end
		for (int k = 0; k < 3; k++) begin
			sr_wr(by_a[k], 16'hFFFF);
			sr_rd(by_a[k]);
			check("byte_reg", d, {8'h00, by_m[k]});
		end
		irq_source_i = 8'($random(seed));
		sr_wr({IX_IIR, MOD_AP}, 16'hFFFF);
		sr_rd({IX_IIR, MOD_AP});
		check("read_only", d, {8'h00, irq_source_i});
		sr_rd(8'h38);
		check("unmapped", {h, d}, 17'h0_0000);
		sr_rd(8'h2A);
		check("unmapped", {h, d}, 17'h0_0000);
		host_any = 1'b1;
		host_val = 1'b1;
		host_req = 1'b1;
		cyc(6);
		host_req = 1'b0;
		host_any = 1'b0;
		// host must see the request low before the next one, or it stays spent
		cyc(2);
		check("loader_mode", loader_mode_o, 1'b0);
		ext_rst(1'b1, 1'b1);
		check("loader_mode", loader_mode_o, 1'b1);
		for (int k = 0; k < PW_WORDS; k++) begin
			pw_q[k] = 16'($random(seed));
			fl_wr(PW_FIRST + 16'(k), pw_q[k]);
		end
		pw_send(5, 1'b0);
		ops(1'b0, 1'b1);
		pw_send(-1, 1'b1);
		ops(1'b1, 1'b1);
		// bit1 and bit6 low: lock and programming enable both cleared
		sr_wr({IX_SC, MOD_AP}, 16'h0080);
		sr_rd({IX_SC, MOD_AP});
		check("system_control", {d, loader_mode_o}, 17'h0_0100);
		ext_rst(1'b0, 1'b0);
		check("grant_mode", {debug_grant_o, loader_mode_o}, 2'h2);
		rst_i = 1'b1;
		cyc(3);
		rst_i = 1'b0;
		cyc(3);
		check("debug_grant", debug_grant_o, 1'b0);
		for (int k = 0; k < PW_WORDS; k++)
			fl_wr(PW_FIRST + 16'(k), pw_q[k]);
		mass_erase_i = 1'b1;
		cyc(1);
		mass_erase_i = 1'b0;
		pw_send(-1, 1'b0);
		for (int k = 0; k < PW_WORDS; k++)
			pw_q[k] = WORD_ONES;
		pw_send(-1, 1'b1);
		for (int w = 0; w < 2; w++) begin
			sr_wr({IX_CLOCK_CONTROL, MOD_AP}, 16'h0010 | 16'(w << CK_WAITXT_BIT));
			// stop bit is registered first, the mode one edge later
			cyc(1);
			check("clk_ctl", {clk_ctl_o, rom_call_ok_o}, 5'h00);
			sr_rd({4'h0, MOD_A});
			check("stop_hit", h, 1'b0);
			ext_int_i = 8'h04;
			cyc(6);
			check("clk_ctl", clk_ctl_o, 4'h0);
			ext_int_en_i = 8'h04;
			for (int i = 0; i < 8 && clk_ctl_o === 4'h0; i++)
				@(negedge clock_i);
			check("warm", {clk_ctl_o.on_rc, clk_ctl_o.clk_run}, {1'b1, w == 0});
			ext_int_i = 8'h00;
			ext_int_en_i = 8'h00;
			cyc(12);
			check("on_rc", clk_ctl_o.on_rc, 1'b0);
		end
		results();
	end
endmodule : bsec_core_test

// file: bsec_jtag_host.sv
// bsec_jtag_host: behavioural programming host writing the programming enable bit.
// assumes the bench raises req_i and drops it once the write is done.
`timescale 1ns/1ps
module bsec_jtag_host (
	input  wire logic       clock_i,
	input  wire logic       in_reset_i,
	input  wire logic       req_i,
	input  wire logic       any_i,
	input  wire logic       val_i,
	input  wire logic [1:0] lag_i,
	output logic            tap_spe_wr_o,
	output logic            tap_spe_val_o
);
	logic [1:0] wait_q = 2'h0;
	logic       sent_q = 1'b0;
	initial begin
		tap_spe_wr_o = 1'b0;
		tap_spe_val_o = 1'b0;
	end
	always @(negedge clock_i) begin
		tap_spe_wr_o <= 1'b0;
		// idle data wanders so a stale value is never read as valid
		tap_spe_val_o <= ~tap_spe_val_o;
		if (!req_i) begin
			sent_q <= 1'b0;
			wait_q <= lag_i;
		end else if (!sent_q && (in_reset_i || any_i)) begin
			if (wait_q != 2'h0) begin
				wait_q <= wait_q - 2'h1;
			end else begin
				tap_spe_wr_o <= 1'b1;
				tap_spe_val_o <= val_i;
				sent_q <= 1'b1;
			end
		end
	end
endmodule : bsec_jtag_host

// file: bsec_pkg.sv
// bsec_pkg: constants and types for the boot, security and system register block.
// assumes one 250 MHz clock; pin inputs are synchronised inside the block.
package bsec_pkg;

	localparam int          CLK_MHZ        = 250;
	localparam logic [15:0] ROM_BASE       = 16'h8000;
	localparam logic [15:0] APP_ENTRY      = 16'h0000;
	localparam logic [15:0] PW_FIRST       = 16'h0010;
	localparam logic [15:0] PW_LAST        = 16'h001F;
	localparam int          PW_WORDS       = 16;
	localparam logic [15:0] WORD_ONES      = 16'hFFFF;

	// module specifiers
	localparam logic [3:0] MOD_AP  = 4'h8;
	localparam logic [3:0] MOD_A   = 4'h9;
	localparam logic [3:0] MOD_PFX = 4'hB;
	localparam logic [3:0] MOD_IP  = 4'hC;
	localparam logic [3:0] MOD_SP  = 4'hD;
	localparam logic [3:0] MOD_DPC = 4'hE;
	localparam logic [3:0] MOD_DP  = 4'hF;

	// indices in the accumulator control module
	localparam logic [3:0] IX_AP   = 4'h0;
	localparam logic [3:0] IX_APC  = 4'h1;
	localparam logic [3:0] IX_PSF  = 4'h4;
	localparam logic [3:0] IX_IC   = 4'h5;
	localparam logic [3:0] IX_IMR  = 4'h6;
	localparam logic [3:0] IX_SC   = 4'h8;
	localparam logic [3:0] IX_IIR  = 4'hB;
	localparam logic [3:0] IX_CLOCK_CONTROL = 4'hE;
	localparam logic [3:0] IX_WATCHDOG_CONTROL = 4'hF;
	// other modules
	localparam logic [3:0] IX_IP   = 4'h0;
	localparam logic [3:0] IX_SP   = 4'h1;
	localparam logic [3:0] IX_IV   = 4'h2;
	localparam logic [3:0] IX_LC0  = 4'h6;
	localparam logic [3:0] IX_LC1  = 4'h7;
	localparam logic [3:0] IX_FRAME_INDEX_DISPLACEMENT = 4'h3;
	localparam logic [3:0] IX_DPC  = 4'h4;
	localparam logic [3:0] IX_GR   = 4'h5;
	localparam logic [3:0] IX_GRL  = 4'h6;
	localparam logic [3:0] IX_BP   = 4'h7;
	localparam logic [3:0] IX_GRS  = 4'h8;
	localparam logic [3:0] IX_GRH  = 4'h9;
	localparam logic [3:0] IX_GENERAL_REGISTER_SIGN_EXTENDED_LOW = 4'hA;
	localparam logic [3:0] IX_FP   = 4'hB;
	localparam logic [3:0] IX_DP0  = 4'h3;
	localparam logic [3:0] IX_DP1  = 4'h7;
	localparam int         PFX_CNT = 8;

	// reset values
	localparam logic [7:0]  PSF_RST  = 8'h80;
	localparam logic [7:0]  SC_RST   = 8'h80;
	localparam logic [15:0] SP_RST   = 16'h000F;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;

	// write masks of the partly writable registers
	localparam logic [7:0] AP_WMASK   = 8'h0F;
	localparam logic [7:0] APC_WMASK  = 8'hC7;
	localparam logic [7:0] PSF_WMASK  = 8'h18;
	localparam logic [7:0] IC_WMASK   = 8'h23;
	localparam logic [7:0] IMR_WMASK  = 8'hBF;
	localparam logic [7:0] SC_WMASK   = 8'hBC;
	localparam logic [7:0] CLOCK_CONTROL_WMASK = 8'h18;
	localparam logic [7:0] WATCHDOG_CONTROL_WMASK = 8'h3F;

	// control bit positions
	localparam int SC_PWL_BIT     = 1;
	localparam int SC_SPE_BIT     = 6;
	localparam int CK_WAITXT_BIT  = 3;
	localparam int CK_STOP_BIT    = 4;

	typedef enum logic [1:0] {
		BSEC_RUN,
		BSEC_STOP,
		BSEC_WARM
	} bsec_mode_t;

	typedef enum logic [2:0] {
		BSEC_OP_LOAD,
		BSEC_OP_DUMP,
		BSEC_OP_CRC,
		BSEC_OP_VERIFY,
		BSEC_OP_ERASE
	} bsec_op_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} bsec_sreq_t;

	typedef struct packed {
		logic osc_en;
		logic rc_en;
		logic clk_run;
		logic on_rc;
	} bsec_clk_t;

endpackage : bsec_pkg
